// File: hw/scg_clock_gate.v
// unit clock gating registers with avalon-mm slave, fault answer and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "scg_map.vh"

module scg_clock_gate (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rst_n,
	// avalon-mm slave
	input  wire [11:0] avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [3:0]  avs_byteenable,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg  [1:0]  avs_response,
	output wire        avs_waitrequest,
	// power state from the processor
	input  wire        sleepMode,
	input  wire        deepSleepMode,
	// peripheral access check
	input  wire        perReq,
	input  wire [2:0]  perUnit,
	output wire        perFault,
	// unit clock enables
	output reg  [7:0]  unitClkEn,
	// interrupt
	output wire        irq
);

	////////////////////////////////////////////////////////////////////////////
	reg  [31:0] runGate_q;
	reg  [31:0] sleepGate_q;
	reg  [31:0] deepGate_q;
	reg  [31:0] runCfg_q;
	reg  [31:0] intStatus_q;
	reg  [31:0] intMask_q;
	reg         ack_q;
	reg  [31:0] rdData_d;
	reg         hitMap_d;
	reg  [31:0] faultSet_d;
	reg  [31:0] beMask_d;
	wire [7:0]  unitEnD;
	wire [7:0]  faultHit;
	wire        busReq;
	wire        wrTake;
	wire [11:0] wordAddr;
	integer     k;

	assign busReq          = avs_read | avs_write;
	// one wait state per access; read data is formed in the first cycle
	assign avs_waitrequest = busReq & ~ack_q;
	assign wrTake          = avs_write & ack_q;
	assign wordAddr        = {avs_address[11:2], 2'b00};

	always @(posedge sys_clk) begin
		if (!rst_n)
			ack_q <= 1'b0;
		else
			ack_q <= busReq & ~ack_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// byte enables and read decode
	always @* begin
		beMask_d = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		hitMap_d = 1'b1;
		case (wordAddr)
			`SCG_OFS_RUN_GATE:   rdData_d = runGate_q;
			`SCG_OFS_SLEEP_GATE: rdData_d = sleepGate_q;
			`SCG_OFS_DEEP_GATE:  rdData_d = deepGate_q;
			`SCG_OFS_RUN_CFG:    rdData_d = runCfg_q;
			`SCG_OFS_INT_STATUS: rdData_d = intStatus_q;
			`SCG_OFS_INT_MASK:   rdData_d = intMask_q;
			default: begin
				rdData_d = 32'h0000_0000;
				hitMap_d = 1'b0;
			end
		endcase
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
			avs_response <= `SCG_RESP_OKAY;
		end else if (busReq & ~ack_q) begin
			avs_readdata <= avs_read ? rdData_d : 32'h0000_0000;
			avs_response <= hitMap_d ? `SCG_RESP_OKAY : `SCG_RESP_SLVERR;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// gating words, mask and run config; only the eight unit bits (run config: bit 0) are storable, the rest read zero
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			runGate_q   <= `SCG_GATE_RESET;
			sleepGate_q <= `SCG_GATE_RESET;
			deepGate_q  <= `SCG_GATE_RESET;
			runCfg_q    <= `SCG_CFG_RESET;
			intMask_q   <= `SCG_GATE_RESET;
		end else if (wrTake) begin
			case (wordAddr)
				`SCG_OFS_RUN_GATE:
					runGate_q <= (runGate_q & ~beMask_d) |
					             (avs_writedata & beMask_d & `SCG_GATE_WMASK);
				`SCG_OFS_SLEEP_GATE:
					sleepGate_q <= (sleepGate_q & ~beMask_d) |
					               (avs_writedata & beMask_d & `SCG_GATE_WMASK);
				`SCG_OFS_DEEP_GATE:
					deepGate_q <= (deepGate_q & ~beMask_d) |
					              (avs_writedata & beMask_d & `SCG_GATE_WMASK);
				`SCG_OFS_RUN_CFG:
					runCfg_q <= (runCfg_q & ~beMask_d) |
					            (avs_writedata & beMask_d & `SCG_CFG_WMASK);
				`SCG_OFS_INT_MASK:
					intMask_q <= (intMask_q & ~beMask_d) |
					             (avs_writedata & beMask_d & `SCG_GATE_WMASK);
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// enable selection and fault check
	scg_gate_select u_select (
		.runGate       (runGate_q),
		.sleepGate     (sleepGate_q),
		.deepGate      (deepGate_q),
		.autoGate      (runCfg_q[`SCG_POS_AUTO_GATE]),
		.sleepMode     (sleepMode),
		.deepSleepMode (deepSleepMode),
		.unitEnD       (unitEnD)
	);

	// registered so that every unit sees a glitch-free enable
	always @(posedge sys_clk) begin
		if (!rst_n)
			unitClkEn <= 8'h00;
		else
			unitClkEn <= unitEnD;
	end

	scg_fault_check u_fault (
		.perReq   (perReq),
		.perUnit  (perUnit),
		.unitEn   (unitClkEn),
		.perFault (perFault),
		.faultHit (faultHit)
	);

	////////////////////////////////////////////////////////////////////////////
	// fault events, sticky at the unit's bit position, write one to clear
	always @* begin
		faultSet_d = 32'h0000_0000;
		for (k = 0; k < `SCG_UNIT_COUNT; k = k + 1)
			faultSet_d[`SCG_UNIT_POS(k)] = faultHit[k];
	end

	// a fault in the clearing cycle survives: set wins over clear
	always @(posedge sys_clk) begin
		if (!rst_n)
			intStatus_q <= `SCG_GATE_RESET;
		else if (wrTake && wordAddr == `SCG_OFS_INT_STATUS)
			intStatus_q <= (intStatus_q & ~(avs_writedata & beMask_d)) | faultSet_d;
		else
			intStatus_q <= intStatus_q | faultSet_d;
	end

	assign irq = |(intStatus_q & intMask_q);

endmodule // scg_clock_gate
`default_nettype wire

// File: hw/scg_fault_check.v
// bus fault decision for accesses aimed at gated units
`timescale 1ns/1ps
`default_nettype none
`include "scg_map.vh"

module scg_fault_check (
	// peripheral access
	input  wire       perReq,
	input  wire [2:0] perUnit,
	// current enables
	input  wire [7:0] unitEn,
	// answers
	output wire       perFault,
	output wire [7:0] faultHit
);

	genvar i;
	generate
		for (i = 0; i < `SCG_UNIT_COUNT; i = i + 1) begin : g_unit
			localparam [2:0] U = i;
			// an unclocked unit cannot complete, so the access faults
			assign faultHit[i] = perReq & (perUnit == U) & ~unitEn[i];
		end
	endgenerate

	assign perFault = |faultHit;

endmodule // scg_fault_check
`default_nettype wire

// File: hw/scg_gate_select.v
// per-unit choice of the clock enable from the run, sleep and deep-sleep gating words
`timescale 1ns/1ps
`default_nettype none
`include "scg_map.vh"

module scg_gate_select (
	// gating words
	input  wire [31:0] runGate,
	input  wire [31:0] sleepGate,
	input  wire [31:0] deepGate,
	// power state
	input  wire        autoGate,
	input  wire        sleepMode,
	input  wire        deepSleepMode,
	// chosen enables
	output wire [7:0]  unitEnD
);

	wire useSleep;
	wire useDeep;

	// sleep words apply only with automatic gating chosen
	assign useDeep  = autoGate & deepSleepMode;
	assign useSleep = autoGate & sleepMode & ~deepSleepMode;

	genvar i;
	generate
		for (i = 0; i < `SCG_UNIT_COUNT; i = i + 1) begin : g_unit
			localparam integer P = `SCG_UNIT_POS(i);
			assign unitEnD[i] = useDeep  ? deepGate[P] :
			                    useSleep ? sleepGate[P] : runGate[P];
		end
	endgenerate

endmodule // scg_gate_select
`default_nettype wire

// File: shared/scg_map.vh
// register map, field positions and reset values of the unit clock gating block
`ifndef SCG_MAP_VH
`define SCG_MAP_VH

`define SCG_SYS_CTRL_BASE   32'h400F_E000
`define SCG_OFS_RUN_GATE    12'h104
`define SCG_OFS_SLEEP_GATE  12'h114
`define SCG_OFS_DEEP_GATE   12'h124
`define SCG_OFS_RUN_CFG     12'h200
`define SCG_OFS_INT_STATUS  12'h210
`define SCG_OFS_INT_MASK    12'h214

`define SCG_POS_ASYNC_A     0
`define SCG_POS_ASYNC_B     1
`define SCG_POS_SYNC_SER    4
`define SCG_POS_QUAD_DEC    8
`define SCG_POS_GP_A        16
`define SCG_POS_GP_B        17
`define SCG_POS_GP_C        18
`define SCG_POS_COMPARATOR_ZERO_GATE       24
`define SCG_POS_AUTO_GATE   0

`define SCG_UNIT_COUNT      8
`define SCG_UNIT_POS(i) ((i)==0 ? `SCG_POS_ASYNC_A : (i)==1 ? `SCG_POS_ASYNC_B : \
	(i)==2 ? `SCG_POS_SYNC_SER : (i)==3 ? `SCG_POS_QUAD_DEC : (i)==4 ? `SCG_POS_GP_A : \
	(i)==5 ? `SCG_POS_GP_B : (i)==6 ? `SCG_POS_GP_C : `SCG_POS_COMPARATOR_ZERO_GATE)

`define SCG_GATE_WMASK      32'h0107_0113
`define SCG_CFG_WMASK       32'h0000_0001
`define SCG_GATE_RESET      32'h0000_0000
`define SCG_CFG_RESET       32'h0000_0000

`define SCG_RESP_OKAY       2'h0
`define SCG_RESP_SLVERR     2'h2

`endif

// File: test/scg_clock_gate_checker.sv
// port assertions of the unit clock gating block
`timescale 1ns/1ps
`default_nettype none
`include "scg_map.vh"
module scg_clock_gate_checker (
	// clock, reset, bus
	input wire        sys_clk,
	input wire        rst_n,
	input wire [11:0] avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_readdata,
	input wire [1:0]  avs_response,
	input wire        avs_waitrequest,
	// power state, access check, enables
	input wire        sleepMode,
	input wire        deepSleepMode,
	input wire        perReq,
	input wire [2:0]  perUnit,
	input wire        perFault,
	input wire [7:0]  unitClkEn,
	input wire        irq
);
	wire       req = avs_read | avs_write;
	wire [9:0] wa  = avs_address[11:2];
	// word offsets 0x104 0x114 0x124 0x200 0x210 0x214
	wire       hit = wa == 10'h041 || wa == 10'h045 || wa == 10'h049 ||
		wa == 10'h080 || wa == 10'h084 || wa == 10'h085;
	wire       ans = req && !avs_waitrequest;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence oneWait; avs_waitrequest ##1 !avs_waitrequest; endsequence
	AST_ONE_WAIT: assert property ($rose(req) |-> oneWait)
		else $error("wait state count wrong");
	AST_GATED_FAULT: assert property (perReq && !unitClkEn[perUnit] |-> perFault)
		else $error("missing fault");
	AST_OPEN_CLEAN: assert property (perReq && unitClkEn[perUnit] |-> !perFault)
		else $error("fault on clocked unit");
	AST_RESET_ZERO: assert property ($rose(rst_n) |-> unitClkEn == 8'h00 && !irq)
		else $error("enables not zero after reset");
	AST_UNMAPPED: assert property (ans && !hit |-> avs_response == `SCG_RESP_SLVERR && avs_readdata == 32'h0)
		else $error("unmapped answer wrong");
	AST_MAPPED: assert property (ans && hit |-> avs_response == `SCG_RESP_OKAY)
		else $error("mapped answer wrong");
	AST_RSVD_ZERO: assert property (ans && avs_read && wa < 10'h080 |-> (avs_readdata & ~`SCG_GATE_WMASK) == 32'h0)
		else $error("reserved bits not zero");
	// enables may move only after a write or a power state change
	AST_EN_HOLD: assert property (!avs_write && !$past(avs_write) && $stable(sleepMode) && $stable(deepSleepMode) |=> $stable(unitClkEn))
		else $error("enables moved without cause");
endmodule // scg_clock_gate_checker
`default_nettype wire

// File: test/scg_clock_gate_tb.sv
// self-checking bench of the unit clock gating block
`timescale 1ns/1ps
`default_nettype none
`include "scg_map.vh"
module scg_clock_gate_tb;
	logic        sys_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic        sleepMode = 1'b0, deepSleepMode = 1'b0, perReq = 1'b0;
	logic [11:0] avs_address = 12'h000;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, rdata;
	logic [2:0]  perUnit = 3'h0;
	logic [1:0]  rresp;
	wire  [31:0] avs_readdata;
	wire  [1:0]  avs_response;
	wire         avs_waitrequest, perFault, irq;
	wire  [7:0]  unitClkEn;
	int          failures = 0, testsRun = 0, cycles = 0;
	always #25 sys_clk = ~sys_clk;
	scg_clock_gate uut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_byteenable, .avs_writedata, .avs_readdata, .avs_response, .avs_waitrequest,
		.sleepMode, .deepSleepMode, .perReq, .perUnit, .perFault, .unitClkEn, .irq);
	////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		testsRun++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// request held until the rising edge that sees waitrequest low; answer taken there
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge sys_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		rresp = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(rdata, e);
	endtask
	task automatic settle;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic mode(input logic s, input logic d);
		@(posedge sys_clk);
		sleepMode <= s;
		deepSleepMode <= d;
		settle;
	endtask
	task automatic t_reset;
		chk(unitClkEn, 8'h00);
		rdchk(12'h114, 32'h0);
		rdchk(12'h104, 32'h0);
		$display("t_reset done");
	endtask
	task automatic t_layout;
		bus(1'b1, 12'h114, 32'hFFFF_FFFF, 4'hF);
		rdchk(12'h114, 32'h0107_0113);
		bus(1'b1, 12'h104, 32'hFFFF_FFFF, 4'h1);
		rdchk(12'h104, 32'h0000_0013);
		$display("t_layout done");
	endtask
	task automatic t_modes;
		bus(1'b1, 12'h104, 32'h0000_0001, 4'hF);
		bus(1'b1, 12'h114, 32'h0100_0000, 4'hF);
		bus(1'b1, 12'h124, 32'h0000_0010, 4'hF);
		settle;
		chk(unitClkEn, 8'h01);
		mode(1'b1, 1'b0);
		chk(unitClkEn, 8'h01);
		bus(1'b1, 12'h200, 32'h0000_0001, 4'hF);
		settle;
		chk(unitClkEn, 8'h80);
		mode(1'b1, 1'b1);
		chk(unitClkEn, 8'h04);
		mode(1'b0, 1'b0);
		chk(unitClkEn, 8'h01);
		$display("t_modes done");
	endtask
	task automatic t_fault;
		@(posedge sys_clk);
		perReq <= 1'b1;
		perUnit <= 3'h1;
		#1;
		chk(perFault, 1'b1);
		@(posedge sys_clk);
		perUnit <= 3'h0;
		#1;
		chk(perFault, 1'b0);
		@(posedge sys_clk);
		perReq <= 1'b0;
		rdchk(12'h210, 32'h0000_0002);
		chk(irq, 1'b0);
		bus(1'b1, 12'h214, 32'h0000_0002, 4'hF);
		settle;
		chk(irq, 1'b1);
		bus(1'b1, 12'h210, 32'h0000_0002, 4'hF);
		settle;
		chk(irq, 1'b0);
		rdchk(12'h210, 32'h0);
		$display("t_fault done");
	endtask
	task automatic t_unmapped;
		bus(1'b1, 12'h300, 32'hFFFF_FFFF, 4'hF);
		chk(rresp, 2'h2);
		rdchk(12'h300, 32'h0);
		chk(rresp, 2'h2);
		rdchk(12'h114, 32'h0100_0000);
		$display("t_unmapped done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", testsRun, failures);
		if (failures == 0 && testsRun > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset;
		t_layout;
		t_modes;
		t_fault;
		t_unmapped;
		complete_run;
	end
	// the whole run needs under a hundred cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			complete_run;
		end
	end
endmodule // scg_clock_gate_tb
bind scg_clock_gate scg_clock_gate_checker u_chk (.sys_clk, .rst_n, .avs_address, .avs_read,
	.avs_write, .avs_readdata, .avs_response, .avs_waitrequest, .sleepMode, .deepSleepMode,
	.perReq, .perUnit, .perFault, .unitClkEn, .irq);
`default_nettype wire
